// ==== pat_pkg.sv ====
// Package for the path and attention tracker: message codes, field widths,
// table depth, mode page layout. Used by pat_tracker, pat_checker, pat_host_model and tb.
// Functional notes
// [RULE_01] All frames of one task stay on one logical path for its life.
// [RULE_02] Logical path of a pair is named only by reply route identifier.
// [RULE_03] Order holds within a path; different paths may reorder frames.
// [RULE_04] Initiator sends every abort and reset over each path it used.
// [RULE_05] Initiator sends a node probe over each alternate path it uses.
// [RULE_06] Node probe creates a table entry holding reply route and port.
// [RULE_07] Unit attention sets one shared flag per affected initiator.
// [RULE_08] Attention caused by a message spares the sending initiator.
// [RULE_09] Command finds entry by route; set flag is cleared, check condition.
// [RULE_10] Third-party devices are named by an 8-byte unique identifier.
// [RULE_11] Ten-byte reserve and release need the extended identifier bit.
// [RULE_12] Copy, copy and verify, compare carry unique identifier in segment.
// [RULE_13] Only the configuration master may issue third-party commands.
// [RULE_14] Six-byte reserve and release third-party option is refused.
// [RULE_15] Initiator may turn six-byte third-party requests into ten-byte ones.
// [RULE_16] Terminate task is unsupported and has no serial message.
// [RULE_17] Listed disconnect/reconnect page 02h parameters have no effect.
// [RULE_18] Mode sense returns page 02h values as written by mode select.
// [RULE_19] Queue type: simple 11b, ordered 10b, head 01b, ACA 00b, with tag.
// [RULE_20] Linked completion: status with link set; flag bit only with flag.
// [RULE_21] Rejections go out as response or unsolicited alert, never reject.
// [RULE_22] Plain completion: status byte in status, link and flag clear.
// [RULE_23] Table depth is a parameter; reset clears all attention flags.
package pat_pkg;
  localparam int TBL_DEPTH = 8;
  localparam int IDX_W     = 3;
  localparam int ROUTE_W   = 16;
  localparam int PORT_W    = 2;
  localparam int TAG_W     = 16;
  localparam int UID_W     = 64;
  localparam int PAGE_LEN  = 16;

  // Serial message kinds seen on the input side
  localparam logic [7:0] MSG_COMMAND  = 8'h01;
  localparam logic [7:0] MSG_PROBE    = 8'h02;
  localparam logic [7:0] MSG_TERMINATE = 8'h11;

  // Task queue type codes
  localparam logic [1:0] QT_SIMPLE  = 2'b11;
  localparam logic [1:0] QT_ORDERED = 2'b10;
  localparam logic [1:0] QT_HEAD    = 2'b01;
  localparam logic [1:0] QT_ACA     = 2'b00;

  // Outgoing message kinds
  localparam logic [1:0] OUT_STATUS   = 2'b01;
  localparam logic [1:0] OUT_RESPONSE = 2'b10;
  localparam logic [1:0] OUT_ALERT    = 2'b11;

  localparam logic [7:0] ST_GOOD  = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;

  // Response codes
  localparam logic [7:0] RSP_OK          = 8'h00;
  localparam logic [7:0] RSP_UNSUPPORTED = 8'h01;
  localparam logic [7:0] RSP_NOT_MASTER  = 8'h02;
  localparam logic [7:0] RSP_BAD_ID      = 8'h03;
  localparam logic [7:0] ALERT_UNKNOWN_ROUTE = 8'h01;

  // Command opcodes checked for third-party handling
  localparam logic [7:0] OP_RESERVE6  = 8'h16;
  localparam logic [7:0] OP_RELEASE6  = 8'h17;
  localparam logic [7:0] OP_RESERVE10 = 8'h56;
  localparam logic [7:0] OP_RELEASE10 = 8'h57;
  localparam logic [7:0] OP_COPY      = 8'h18;
  localparam logic [7:0] OP_COMPARE   = 8'h39;
  localparam logic [7:0] OP_COPY_VER  = 8'h3A;

  // Page 02h byte positions that only store, never steer
  localparam logic [7:0] PAGE_CODE    = 8'h02;
  localparam logic [3:0] PG_BUS_INACT = 4'h4;
  localparam logic [3:0] PG_DIS_TIME  = 4'h6;
  localparam logic [3:0] PG_CON_TIME  = 4'h8;
  localparam logic [3:0] PG_BURST     = 4'hA;
  localparam logic [3:0] PG_TRANSFER_DISCONNECT_CONTROL_BYTE = 4'hC;
  localparam logic [7:0] PG_RESET_VAL = 8'h00;
endpackage

// ==== pat_tracker.sv ====
// Target-side tracker: initiator table, shared attention flags, third-party
// checks, completion message build and page 02h store.
// Assumes decoded message fields arrive from logic on the same clock.
`timescale 1ns/1ps
module pat_tracker (
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  // Decoded incoming serial message
  input  wire logic                        i_msg_valid,
  input  wire logic [7:0]                  i_msg_kind,
  input  wire logic [pat_pkg::ROUTE_W-1:0] i_reply_route_identifier,
  input  wire logic [pat_pkg::PORT_W-1:0]  i_rx_port,
  input  wire logic [pat_pkg::TAG_W-1:0]   i_tag,
  input  wire logic [1:0]                  i_task_queue_type,
  input  wire logic [7:0]                  i_opcode,
  input  wire logic                        i_third_party,
  input  wire logic                        i_extended_identifier_bit,
  input  wire logic [pat_pkg::UID_W-1:0]   i_third_party_uid,
  input  wire logic                        i_sender_is_master,
  // Unit attention event from the logical unit
  input  wire logic                        i_ua_event,
  input  wire logic                        i_ua_from_msg,
  input  wire logic [pat_pkg::ROUTE_W-1:0] i_ua_route,
  // Command completion from the logical unit
  input  wire logic                        i_done_valid,
  input  wire logic [pat_pkg::ROUTE_W-1:0] i_done_route,
  input  wire logic [pat_pkg::TAG_W-1:0]   i_done_tag,
  input  wire logic [7:0]                  i_done_status,
  input  wire logic                        i_done_linked,
  input  wire logic                        i_done_flag,
  // Page 02h access
  input  wire logic                        i_page_wr,
  input  wire logic                        i_page_save,
  input  wire logic                        i_page_rd,
  input  wire logic                        i_page_saved_sel,
  input  wire logic [3:0]                  i_page_addr,
  input  wire logic [7:0]                  i_page_wdata,
  output logic [7:0]                       o_page_rdata,
  // Command passed to the logical unit
  output logic                             o_cmd_valid,
  output logic [pat_pkg::ROUTE_W-1:0]      o_cmd_route,
  output logic [pat_pkg::TAG_W-1:0]        o_cmd_tag,
  output logic [1:0]                       o_cmd_queue_type,
  output logic [7:0]                       o_cmd_opcode,
  output logic [pat_pkg::UID_W-1:0]        o_cmd_uid,
  // Outgoing serial message
  output logic                             o_out_valid,
  output logic [1:0]                       o_out_kind,
  output logic [pat_pkg::ROUTE_W-1:0]      o_out_route,
  output logic [pat_pkg::PORT_W-1:0]       o_out_port,
  output logic [pat_pkg::TAG_W-1:0]        o_out_tag,
  output logic [7:0]                       o_out_code,
  output logic                             o_out_link,
  output logic                             o_out_flag,
  output logic                             o_sense_valid,
  output logic [pat_pkg::IDX_W:0]          o_entries
);
  import pat_pkg::*;

  // ----------------------------------------------------------------------
  // Initiator table
  // ----------------------------------------------------------------------
  logic                 ent_valid_ff [TBL_DEPTH];
  logic [ROUTE_W-1:0]   ent_route_ff [TBL_DEPTH];
  logic [PORT_W-1:0]    ent_port_ff  [TBL_DEPTH];
  logic                 ua_flag_ff   [TBL_DEPTH];
  logic [IDX_W:0]       entries_ff;

  typedef struct packed {
    logic             hit;
    logic [IDX_W-1:0] idx;
  } pat_find_t;

  // Route lookup; a route names exactly one path of one initiator
  function automatic pat_find_t find_route(input logic [ROUTE_W-1:0] r);
    pat_find_t f;
    f = '0;
    for (int i = TBL_DEPTH - 1; i >= 0; i--) begin
      if (ent_valid_ff[i] && ent_route_ff[i] == r) begin
        f.hit = 1'b1;
        f.idx = IDX_W'(i);
      end
    end
    return f;
  endfunction // [RULE_02]

  function automatic pat_find_t find_free();
    pat_find_t f;
    f = '0;
    for (int i = TBL_DEPTH - 1; i >= 0; i--) begin
      if (!ent_valid_ff[i]) begin
        f.hit = 1'b1;
        f.idx = IDX_W'(i);
      end
    end
    return f;
  endfunction

  pat_find_t msg_hit;
  pat_find_t free_slot;
  pat_find_t done_hit;
  always_comb begin
    msg_hit   = find_route(i_reply_route_identifier);
    free_slot = find_free();
    done_hit  = find_route(i_done_route);
  end

  logic is_probe;
  logic is_cmd;
  logic is_term;
  assign is_probe = i_msg_valid && i_msg_kind == MSG_PROBE;
  assign is_cmd   = i_msg_valid && i_msg_kind == MSG_COMMAND;
  assign is_term  = i_msg_valid && i_msg_kind == MSG_TERMINATE;

  logic probe_new;
  assign probe_new = is_probe && !msg_hit.hit && free_slot.hit;

  // One entry per path; a repeated probe only refreshes the port.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < TBL_DEPTH; i++) begin
        ent_valid_ff[i] <= 1'b0;
        ent_route_ff[i] <= '0;
        ent_port_ff[i]  <= '0;
      end
      entries_ff <= '0;
    end else if (is_probe) begin
      if (msg_hit.hit) begin
        ent_port_ff[msg_hit.idx] <= i_rx_port; // [RULE_06]
      end else if (free_slot.hit) begin
        ent_valid_ff[free_slot.idx] <= 1'b1; // [RULE_06]
        ent_route_ff[free_slot.idx] <= i_reply_route_identifier;
        ent_port_ff[free_slot.idx]  <= i_rx_port;
        entries_ff <= entries_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Attention flags
  // ----------------------------------------------------------------------
  // One flag per initiator, mirrored in every path entry of the same owner.
  function automatic logic same_owner(input logic [ROUTE_W-1:0] a,
                                      input logic [ROUTE_W-1:0] b);
    return a[ROUTE_W-1:8] == b[ROUTE_W-1:8];
  endfunction

  logic ua_consume;
  assign ua_consume = is_cmd && msg_hit.hit && ua_flag_ff[msg_hit.idx];

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < TBL_DEPTH; i++) begin
        ua_flag_ff[i] <= 1'b0; // [RULE_23]
      end
    end else begin
      for (int i = 0; i < TBL_DEPTH; i++) begin
        // New attention wins over a same-cycle consume
        if (i_ua_event && ent_valid_ff[i] &&
            !(i_ua_from_msg && same_owner(ent_route_ff[i], i_ua_route))) begin
          ua_flag_ff[i] <= 1'b1; // [RULE_07] [RULE_08]
        end else if (ua_consume &&
                     same_owner(ent_route_ff[i], i_reply_route_identifier)) begin
          ua_flag_ff[i] <= 1'b0; // [RULE_09]
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Command screening
  // ----------------------------------------------------------------------
  logic tp_short;
  logic tp_long_bad;
  logic tp_forbidden;
  logic tp_no_uid;
  assign tp_short    = i_third_party &&
                       (i_opcode == OP_RESERVE6 || i_opcode == OP_RELEASE6);
  assign tp_long_bad = i_third_party && !i_extended_identifier_bit &&
                       (i_opcode == OP_RESERVE10 || i_opcode == OP_RELEASE10);
  assign tp_forbidden = i_third_party && !i_sender_is_master;
  assign tp_no_uid   = i_third_party && i_third_party_uid == '0 &&
                       (i_opcode == OP_COPY || i_opcode == OP_COMPARE ||
                        i_opcode == OP_COPY_VER);

  logic cmd_ok;
  assign cmd_ok = is_cmd && msg_hit.hit && !ua_consume && !tp_short &&
                  !tp_long_bad && !tp_forbidden && !tp_no_uid;

  // Route kept with the command so its completion stays on its path.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_cmd_valid      <= 1'b0;
      o_cmd_route      <= '0;
      o_cmd_tag        <= '0;
      o_cmd_queue_type <= QT_SIMPLE;
      o_cmd_opcode     <= '0;
      o_cmd_uid        <= '0;
    end else begin
      o_cmd_valid <= cmd_ok;
      if (cmd_ok) begin
        o_cmd_route      <= i_reply_route_identifier; // [RULE_01]
        o_cmd_tag        <= i_tag; // [RULE_19]
        o_cmd_queue_type <= i_task_queue_type; // [RULE_19]
        o_cmd_opcode     <= i_opcode;
        o_cmd_uid        <= i_third_party ? i_third_party_uid : '0; // [RULE_10] [RULE_12]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outgoing messages
  // ----------------------------------------------------------------------
  // Refusals outrank a same-cycle completion, which is then lost; the
  // logical unit must not complete beside a refused command.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_out_valid   <= 1'b0;
      o_out_kind    <= OUT_STATUS;
      o_out_route   <= '0;
      o_out_port    <= '0;
      o_out_tag     <= '0;
      o_out_code    <= ST_GOOD;
      o_out_link    <= 1'b0;
      o_out_flag    <= 1'b0;
      o_sense_valid <= 1'b0;
    end else begin
      o_out_valid   <= 1'b0;
      o_sense_valid <= 1'b0;
      o_out_link    <= 1'b0;
      o_out_flag    <= 1'b0;
      if (i_msg_valid && !msg_hit.hit && !is_probe) begin
        o_out_valid <= 1'b1;
        o_out_kind  <= OUT_ALERT; // [RULE_21]
        o_out_route <= i_reply_route_identifier;
        o_out_port  <= i_rx_port;
        o_out_tag   <= i_tag;
        o_out_code  <= ALERT_UNKNOWN_ROUTE;
      end else if (is_cmd && ua_consume) begin
        o_out_valid   <= 1'b1;
        o_out_kind    <= OUT_STATUS; // [RULE_09]
        o_out_route   <= i_reply_route_identifier; // [RULE_01]
        o_out_port    <= ent_port_ff[msg_hit.idx];
        o_out_tag     <= i_tag;
        o_out_code    <= ST_CHECK;
        o_sense_valid <= 1'b1;
      end else if ((is_cmd && !cmd_ok) || is_term) begin
        o_out_valid <= 1'b1;
        o_out_kind  <= OUT_RESPONSE; // [RULE_21]
        o_out_route <= i_reply_route_identifier;
        o_out_port  <= ent_port_ff[msg_hit.idx];
        o_out_tag   <= i_tag;
        if (is_term || tp_short) begin
          o_out_code <= RSP_UNSUPPORTED; // [RULE_14] [RULE_16]
        end else if (tp_forbidden) begin
          o_out_code <= RSP_NOT_MASTER; // [RULE_13]
        end else begin
          o_out_code <= RSP_BAD_ID; // [RULE_11] [RULE_12]
        end
      end else if (i_done_valid && done_hit.hit) begin
        o_out_valid <= 1'b1;
        o_out_kind  <= OUT_STATUS;
        o_out_route <= i_done_route; // [RULE_01] [RULE_03]
        o_out_port  <= ent_port_ff[done_hit.idx];
        o_out_tag   <= i_done_tag;
        o_out_code  <= i_done_status; // [RULE_22]
        o_out_link  <= i_done_linked; // [RULE_20]
        o_out_flag  <= i_done_linked && i_done_flag; // [RULE_20]
      end
    end
  end

  assign o_entries = entries_ff;

  // ----------------------------------------------------------------------
  // Page 02h store
  // ----------------------------------------------------------------------
  // Stored and echoed only: frame multiplexing leaves no timing to steer.
  logic [7:0] page_cur_ff   [PAGE_LEN];
  logic [7:0] page_saved_ff [PAGE_LEN];

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < PAGE_LEN; i++) begin
        page_cur_ff[i]   <= PG_RESET_VAL;
        page_saved_ff[i] <= PG_RESET_VAL;
      end
      page_cur_ff[0] <= PAGE_CODE;
      page_saved_ff[0] <= PAGE_CODE;
    end else begin
      if (i_page_wr && i_page_addr != 4'h0) begin
        page_cur_ff[i_page_addr] <= i_page_wdata; // [RULE_17] [RULE_18]
        if (i_page_save) begin
          page_saved_ff[i_page_addr] <= i_page_wdata; // [RULE_18]
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_page_rdata <= '0;
    end else if (i_page_rd) begin
      o_page_rdata <= i_page_saved_sel ? page_saved_ff[i_page_addr]
                                       : page_cur_ff[i_page_addr]; // [RULE_18]
    end
  end
endmodule // pat_tracker

// ==== pat_checker.sv ====
// Port-level assertions for pat_tracker.
// Assumes one clock, synchronous active-low reset; bound after the module.
`timescale 1ns/1ps
module pat_checker
  import pat_pkg::*;
(
  input wire logic                       i_clk,
  input wire logic                       i_nrst,
  input wire logic                       i_msg_valid,
  input wire logic [7:0]                 i_msg_kind,
  input wire logic [pat_pkg::TAG_W-1:0]  i_tag,
  input wire logic [1:0]                 i_task_queue_type,
  input wire logic                       i_done_valid,
  input wire logic [7:0]                 i_done_status,
  input wire logic                       i_done_linked,
  input wire logic                       i_done_flag,
  input wire logic                       o_cmd_valid,
  input wire logic [pat_pkg::TAG_W-1:0]  o_cmd_tag,
  input wire logic [1:0]                 o_cmd_queue_type,
  input wire logic                       o_out_valid,
  input wire logic [1:0]                 o_out_kind,
  input wire logic [7:0]                 o_out_code,
  input wire logic                       o_out_link,
  input wire logic                       o_out_flag,
  input wire logic                       o_sense_valid,
  input wire logic [pat_pkg::IDX_W:0]    o_entries
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_cmd_in;
    i_msg_valid && i_msg_kind == MSG_COMMAND;
  endsequence
  // Completion alone; one beside a message may be dropped
  sequence s_done_alone;
    i_done_valid && !i_msg_valid;
  endsequence

  cmd_source_a:
    assert property (o_cmd_valid |-> $past(i_msg_valid && i_msg_kind == MSG_COMMAND))
    else $error("command passed on without a command message");
  queue_pass_a:
    assert property (s_cmd_in ##1 o_cmd_valid |->
      o_cmd_queue_type == $past(i_task_queue_type) && o_cmd_tag == $past(i_tag))
    else $error("queue type or tag altered");
  sense_check_a:
    assert property (o_sense_valid |-> o_out_valid && o_out_kind == OUT_STATUS
      && o_out_code == ST_CHECK)
    else $error("sense without check status");
  plain_done_a:
    assert property (s_done_alone ##0 !i_done_linked |=> o_out_valid && o_out_kind == OUT_STATUS
      && !o_out_link && !o_out_flag && o_out_code == $past(i_done_status))
    else $error("plain completion malformed");
  linked_done_a:
    assert property (s_done_alone ##0 i_done_linked |=> o_out_link
      && o_out_flag == $past(i_done_flag))
    else $error("linked completion malformed");
  flag_link_a:
    assert property (o_out_flag |-> o_out_link)
    else $error("flag without link");
  term_refuse_a:
    assert property (i_msg_valid && i_msg_kind == MSG_TERMINATE |=> o_out_valid
      && o_out_kind == OUT_RESPONSE && o_out_code == RSP_UNSUPPORTED && !o_cmd_valid)
    else $error("terminate task not refused");
  entry_step_a:
    assert property (o_entries != $past(o_entries) |->
      $past(i_msg_valid && i_msg_kind == MSG_PROBE) && o_entries == $past(o_entries) + 1'b1)
    else $error("table grew without a probe");
  entry_cap_a:
    assert property (o_entries <= TBL_DEPTH)
    else $error("table count above depth");
  reset_clear_a:
    assert property (disable iff (1'b0) !i_nrst |=> o_entries == '0 && !o_out_valid
      && !o_cmd_valid && !o_sense_valid)
    else $error("reset left state behind");
endmodule // pat_checker

bind pat_tracker pat_checker u_chk (.*);

// ==== pat_host_model.sv ====
// Initiator host controller model: issues decoded serial messages.
// Assumes one caller at a time; each message is a one-cycle pulse.
`timescale 1ns/1ps
module pat_host_model (
  input  wire logic                        i_clk,
  output logic                             o_msg_valid,
  output logic [7:0]                       o_msg_kind,
  output logic [pat_pkg::ROUTE_W-1:0]      o_route,
  output logic [pat_pkg::PORT_W-1:0]       o_rx_port,
  output logic [pat_pkg::TAG_W-1:0]        o_tag,
  output logic [1:0]                       o_qtype,
  output logic [7:0]                       o_opcode,
  output logic                             o_tp,
  output logic                             o_ext,
  output logic [pat_pkg::UID_W-1:0]        o_uid,
  output logic                             o_master
);
  initial begin
    {o_msg_valid, o_msg_kind, o_route, o_rx_port, o_tag, o_qtype} = '0;
    {o_opcode, o_tp, o_ext, o_uid, o_master} = '0;
  end

  // ----------------------------------------
  // Message issue
  // ----------------------------------------
  // One message per call, on the route and port that the caller gives
  task automatic send(input logic [7:0] k, input logic [15:0] r, input logic [1:0] p,
      input logic [15:0] t, input logic [1:0] q, input logic [7:0] op, input logic tp, ext,
      input logic [63:0] u, input logic ms);
    @(posedge i_clk);
    o_msg_valid <= 1'b1;
    {o_msg_kind, o_route, o_rx_port, o_tag, o_qtype} <= {k, r, p, t, q};
    {o_opcode, o_tp, o_ext, o_uid, o_master} <= {op, tp, ext, u, ms};
    @(posedge i_clk);
    o_msg_valid <= 1'b0;
    // Kind, route, tag and uid scrambled once released, so nothing leans on their stale values
    {o_msg_kind, o_route, o_tag, o_uid} <= ~{o_msg_kind, o_route, o_tag, o_uid};
  endtask
endmodule // pat_host_model

// ==== tb.sv ====
// Bench for pat_tracker: table, attention, third party, completion, page.
// Messages come from the host model; other inputs are driven here.
`timescale 1ns/1ps
module tb;
  import pat_pkg::*;
  logic i_clk = 1'b0, i_nrst = 1'b0;
  logic i_msg_valid, i_third_party, i_extended_identifier_bit, i_sender_is_master;
  logic [7:0] i_msg_kind, i_opcode, o_page_rdata, o_cmd_opcode, o_out_code;
  logic [ROUTE_W-1:0] i_reply_route_identifier, o_cmd_route, o_out_route;
  logic [PORT_W-1:0] i_rx_port, o_out_port;
  logic [TAG_W-1:0] i_tag, o_cmd_tag, o_out_tag, i_done_tag = '0;
  logic [1:0] i_task_queue_type, o_cmd_queue_type, o_out_kind;
  logic [UID_W-1:0] i_third_party_uid, o_cmd_uid;
  logic i_ua_event = 1'b0, i_ua_from_msg = 1'b0, i_done_valid = 1'b0;
  logic i_done_linked = 1'b0, i_done_flag = 1'b0, i_page_saved_sel = 1'b0;
  logic i_page_wr = 1'b0, i_page_save = 1'b0, i_page_rd = 1'b0;
  logic [ROUTE_W-1:0] i_ua_route = '0, i_done_route = '0;
  logic [7:0] i_done_status = 8'h00, i_page_wdata = 8'h00;
  logic [3:0] i_page_addr = 4'h0;
  logic o_cmd_valid, o_out_valid, o_out_link, o_out_flag, o_sense_valid;
  logic [IDX_W:0] o_entries;
  int bad_count = 0, cmp_count = 0, cyc = 0;

  always #5 i_clk = ~i_clk;
  pat_tracker dut (.*);
  pat_host_model u_host (.i_clk(i_clk), .o_msg_valid(i_msg_valid), .o_msg_kind(i_msg_kind),
    .o_route(i_reply_route_identifier), .o_rx_port(i_rx_port), .o_tag(i_tag),
    .o_qtype(i_task_queue_type), .o_opcode(i_opcode), .o_tp(i_third_party),
    .o_ext(i_extended_identifier_bit), .o_uid(i_third_party_uid), .o_master(i_sender_is_master));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [15:0] r, input logic [1:0] q, input logic [15:0] t,
      input logic [7:0] op, input logic tp, ext, ms, input logic [63:0] u);
    u_host.send(MSG_COMMAND, r, 2'd0, t, q, op, tp, ext, u, ms);
    #1;
  endtask
  task automatic pcmd(input logic [15:0] r, t);
    cmd(r, QT_SIMPLE, t, OP_RESERVE6, '0, '0, 1'b1, '0);
  endtask
  task automatic probe(input logic [15:0] r, input logic [1:0] p);
    u_host.send(MSG_PROBE, r, p, '0, 2'b11, '0, '0, '0, '0, '0);
    #1;
  endtask
  task automatic ua(input logic m, input logic [15:0] r);
    @(posedge i_clk);
    {i_ua_event, i_ua_from_msg, i_ua_route} <= {1'b1, m, r};
    @(posedge i_clk);
    i_ua_event <= 1'b0;
  endtask
  task automatic pg(input logic w, sv, rd, sel, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {i_page_wr, i_page_save, i_page_rd, i_page_saved_sel} <= {w, sv, rd, sel};
    {i_page_addr, i_page_wdata} <= {a, d};
    @(posedge i_clk);
    {i_page_wr, i_page_save, i_page_rd, i_page_wdata} <= {3'b000, ~d};
    #1;
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_table();
    probe(16'h0100, 2'd1);
    probe(16'h0101, 2'd2);
    probe(16'h0200, 2'd0);
    chk(o_entries, 3);
    ua(1'b1, 16'h0200);
    pcmd(16'h0101, 16'h0011);
    chk({o_out_valid, o_out_kind, o_out_code, o_sense_valid, o_out_port},
      {1'b1, OUT_STATUS, ST_CHECK, 1'b1, 2'd2});
    pcmd(16'h0100, 16'h0012);
    chk(o_cmd_valid, 1);
    pcmd(16'h0200, 16'h0013);
    chk(o_cmd_valid, 1);
    ua(1'b0, 16'h0000);
    pcmd(16'h0200, 16'h0014);
    chk({o_out_code, o_sense_valid, o_out_port}, {ST_CHECK, 1'b1, 2'd0});
    pcmd(16'h0100, 16'h0015);
    chk({o_out_code, o_sense_valid, o_out_port}, {ST_CHECK, 1'b1, 2'd1});
    pcmd(16'h0300, 16'h0016);
    chk({o_out_valid, o_out_kind, o_out_code},
      {1'b1, OUT_ALERT, ALERT_UNKNOWN_ROUTE});
    u_host.send(MSG_TERMINATE, 16'h0100, 2'd1, 16'h0017, 2'b11, '0, '0, '0, '0, 1'b1);
    #1;
    chk({o_out_valid, o_out_kind, o_out_code}, {1'b1, OUT_RESPONSE, RSP_UNSUPPORTED});
    $display("table and attention test finished");
  endtask
  task automatic t_queue();
    for (int i = 0; i < 4; i++) begin
      cmd(16'h0101, i[1:0], 16'h1000 + i[15:0], OP_RESERVE6, '0, '0, 1'b1, '0);
      chk({o_cmd_valid, o_cmd_queue_type, o_cmd_tag, o_cmd_route, o_cmd_opcode},
        {1'b1, i[1:0], 16'h1000 + i[15:0], 16'h0101, OP_RESERVE6});
    end
    $display("queue type test finished");
  endtask
  task automatic t_third();
    // Row: opcode, ext bit, uid present, master, response or FF for pass
    logic [19:0] row [8] = '{20'h1_6601, 20'h1_7601, 20'h5_6603, 20'h5_7EFF,
                             20'h1_8A03, 20'h3_AEFF, 20'h3_9EFF, 20'h5_6C02};
    logic [63:0] u;
    for (int i = 0; i < 8; i++) begin
      u = row[i][10] ? 64'h0123_4567_89AB_CDEF : 64'h0;
      cmd(16'h0100, QT_ORDERED, 16'h2000, row[i][19:12], 1'b1, row[i][11], row[i][9], u);
      if (row[i][7:0] == 8'hFF)
        chk({o_cmd_valid, o_cmd_uid[62:0]},
          {1'b1, u[62:0]});
      else
        chk({o_cmd_valid, o_out_valid, o_out_kind, o_out_code},
          {2'b01, OUT_RESPONSE, row[i][7:0]});
    end
    $display("third party test finished");
  endtask
  task automatic t_done();
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk);
      {i_done_valid, i_done_route, i_done_status} <= {1'b1, 16'h0100, 8'h40 + i[7:0]};
      {i_done_tag, i_done_linked, i_done_flag} <= {16'h0A00 + i[15:0], i > 0, i == 2};
      @(posedge i_clk);
      i_done_valid <= 1'b0;
      #1;
      chk({o_out_valid, o_out_kind, o_out_code, o_out_link, o_out_flag, o_out_tag, o_out_route},
        {1'b1, OUT_STATUS, 8'h40 + i[7:0], i > 0, i == 2, 16'h0A00 + i[15:0],
        16'h0100});
    end
    $display("completion test finished");
  endtask
  task automatic t_page();
    pg(1'b1, 1'b0, 1'b0, 1'b0, PG_BUS_INACT, 8'h5A);
    pg(1'b1, 1'b1, 1'b0, 1'b0, PG_TRANSFER_DISCONNECT_CONTROL_BYTE, 8'hA5);
    pg(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 8'hFF);
    pg(1'b0, 1'b0, 1'b1, 1'b0, PG_BUS_INACT, 8'h00);
    chk(o_page_rdata, 8'h5A);
    pg(1'b0, 1'b0, 1'b1, 1'b1, PG_TRANSFER_DISCONNECT_CONTROL_BYTE, 8'h00);
    chk(o_page_rdata, 8'hA5);
    pg(1'b0, 1'b0, 1'b1, 1'b1, PG_BUS_INACT, 8'h00);
    chk(o_page_rdata, PG_RESET_VAL);
    pg(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 8'h00);
    chk(o_page_rdata, PAGE_CODE);
    cmd(16'h0101, QT_HEAD, 16'h3000, OP_RESERVE6, '0, '0, 1'b1, '0);
    chk(o_cmd_valid, 1);
    $display("page test finished");
  endtask
  task automatic t_reset();
    ua(1'b0, 16'h0000);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    chk(o_entries, 0);
    probe(16'h0100, 2'd1);
    pcmd(16'h0100, 16'h0077);
    chk(o_cmd_valid, 1);
    $display("reset test finished");
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      $display("Error at %0t: timeout after %h cycles, expected %h", $time, cyc, 0);
      complete_run();
    end
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_table();
    t_queue();
    t_third();
    t_done();
    t_page();
    t_reset();
    complete_run();
  end
endmodule // tb
